/* File: logic/flash_mode_register_bank.sv */
// Flash control, erase block, wait-state and mode control registers on classic Wishbone.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
module flash_mode_register_bank (
  input  wire logic                              clk_i,            // System clock.
  input  wire logic                              rst_i,            // Synchronous reset.
  input  wire logic                              ce_i,             // Clock enable.
  input  wire logic                              cyc_i,            // Wishbone cycle.
  input  wire logic                              stb_i,            // Wishbone strobe.
  input  wire logic                              we_i,             // Wishbone write.
  input  wire logic [flash_mode_pkg::ADR_W-1:0]  adr_i,            // Byte address.
  input  wire logic [3:0]                        sel_i,            // Byte selects.
  input  wire logic [flash_mode_pkg::DAT_W-1:0]  dat_i,            // Write data.
  output logic      [flash_mode_pkg::DAT_W-1:0]  dat_o,            // Read data.
  output logic                                   ack_o,            // Wishbone ack.
  input  wire logic                              mode_pin_one_i,   // Mode pin 1.
  input  wire logic                              mode_pin_zero_i,  // Mode pin 0.
  input  wire logic                              boot_pin_i,       // Boot request pin.
  input  wire logic                              prog_voltage_i,   // Programming voltage.
  input  wire logic                              flash_error_i,    // Flash fault pulse.
  input  wire logic                              comm_ok_i,        // Serial check passed.
  input  wire logic                              load_done_i,      // Routine loaded.
  output logic                                   expanded_o,       // Expanded operation.
  output logic                                   single_chip_o,    // Single-chip operation.
  output logic                                   flash_enabled_o,  // On-chip flash on.
  output logic      [7:0]                        wait_state_o,     // Wait-state control.
  output logic                                   boot_check_o,     // Run serial check.
  output logic                                   routine_load_o,   // Load erase routine.
  output logic                                   program_o,        // Program request.
  output logic                                   program_verify_o, // Program-verify.
  output logic                                   erase_verify_o,   // Erase-verify.
  output logic                                   erase_all_o,      // Total erase request.
  output logic                                   erase_o,          // Block erase request.
  output logic      [7:0]                        erase_blocks_o,   // Blocks to erase.
  output logic      [6:0]                        erase_kbytes_o    // Kbytes to erase.
);
  import flash_mode_pkg::*;

  // Pin synchronisers: stage one feeds stage two only.
  logic [3:0]  pin_meta_reg;
  logic [3:0]  pin_sync_reg;
  logic [1:0]  mode_reg;
  logic        boot_reg;

  // Bus answer and register contents.
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        swe_reg;
  logic        ev_reg;
  logic        pv_reg;
  logic        e_reg;
  logic        p_reg;
  logic        fler_reg;
  logic        esu_reg;
  logic        psu_reg;
  logic [7:0]  ebs_reg;
  logic [7:0]  wsc_reg;
  logic        expanded_mode_enable_reg;

  // Sequencing and decode helpers.
  boot_state_t boot_state_reg;
  boot_state_t boot_state_next;
  reg_sel_t    sel_now;
  logic        req;
  logic        wr_en;
  logic [7:0]  wdat;
  logic        flash_en;
  logic        user_prog;
  logic        boot_ready;
  logic        may_alter;
  logic [7:0]  rd_byte;

  // Registers sit one per 32-bit word, so the two low address bits must be zero.
  // Without the select bit the flash words are unmapped and fall through to zero.
  function automatic reg_sel_t decode(input logic [ADR_W-1:0] a, input logic flsel);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] != 2'h0) begin
      s = SEL_NONE;
    end else if (flsel && a[ADR_W-1:2] == IDX_FC1) begin
      s = SEL_FC1;
    end else if (flsel && a[ADR_W-1:2] == IDX_FC2) begin
      s = SEL_FC2;
    end else if (flsel && a[ADR_W-1:2] == IDX_EBS) begin
      s = SEL_EBS;
    end else if (a[ADR_W-1:2] == IDX_WSC) begin
      s = SEL_WSC;
    end else if (a[ADR_W-1:2] == IDX_MDC) begin
      s = SEL_MDC;
    end
    return s;
  endfunction

  // The sum cannot overflow: all eight blocks together come to 62, well inside the seven bits.
  function automatic logic [6:0] block_kbytes(input logic [7:0] mask);
    logic [6:0] sum;
    sum = 7'h00;
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      if (mask[i]) begin
        sum = sum + BLOCK_KB[i];
      end
    end
    return sum;
  endfunction

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      pin_meta_reg <= {prog_voltage_i, boot_pin_i, mode_pin_one_i, mode_pin_zero_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // The mode follows the pins all through reset and freezes at release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= pin_sync_reg[1:0];
      boot_reg <= pin_sync_reg[2];
    end
  end

  assign flash_en   = (mode_reg != MODE_ONE);
  // The programming voltage is followed live, so removing it stops user programming requests on the third clock edge; boot mode ignores it.
  assign user_prog  = !boot_reg && pin_sync_reg[3];
  assign boot_ready = boot_reg && (boot_state_reg == BOOT_READY);
  // User mode without the programming voltage leaves the flash readable only; a latched fault also blocks changes.
  assign may_alter  = flash_en && !fler_reg && (boot_ready || user_prog);

  assign req     = cyc_i && stb_i && !ack_reg;
  assign sel_now = decode(adr_i, wsc_reg[WSC_FLSEL]);
  // Writes land on the edge where the master sees ack.
  assign wr_en   = cyc_i && stb_i && we_i && ack_reg && sel_i[0];
  assign wdat    = dat_i[7:0];

  // Read data is taken at the request edge, so the pins are latched as the read starts.
  always_comb begin
    rd_byte = 8'h00;
    case (sel_now)
      SEL_FC1: rd_byte = flash_en ? {1'b1, swe_reg, 2'h0, ev_reg, pv_reg, e_reg, p_reg}
                                  : DISABLED_READ;
      SEL_FC2: rd_byte = flash_en ? {fler_reg, 5'h00, esu_reg, psu_reg}
                                  : DISABLED_READ;
      SEL_EBS: rd_byte = flash_en ? ebs_reg : DISABLED_READ;
      SEL_WSC: rd_byte = wsc_reg;
      SEL_MDC: rd_byte = MDC_FIXED | {expanded_mode_enable_reg, 5'h00, pin_sync_reg[1:0]};
      default: rd_byte = 8'h00;
    endcase
  end

  // Every access answers after one cycle; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // The read data register holds the mode pin levels from the moment of the read.
  // A second copy would only duplicate it, so none is kept.

  // Bit 7 reads 1 while the flash is enabled and is not stored.
  // Each mode bit sets only if its enables were already set before this write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swe_reg <= FC1_RESET[FC1_SWE];
      ev_reg  <= FC1_RESET[FC1_EV];
      pv_reg  <= FC1_RESET[FC1_PV];
      e_reg   <= FC1_RESET[FC1_E];
      p_reg   <= FC1_RESET[FC1_P];
    end else if (ce_i) begin
      if (wr_en && sel_now == SEL_FC1 && flash_en) begin
        swe_reg <= wdat[FC1_SWE];
        ev_reg  <= wdat[FC1_EV] && swe_reg;
        pv_reg  <= wdat[FC1_PV] && swe_reg;
        e_reg   <= wdat[FC1_E] && swe_reg && esu_reg;
        p_reg   <= wdat[FC1_P] && swe_reg && psu_reg;
      end else if (!swe_reg) begin
        ev_reg <= 1'b0;
        pv_reg <= 1'b0;
        e_reg  <= 1'b0;
        p_reg  <= 1'b0;
      end
    end
  end

  // The error bit is read only; it clears with the write enable or by reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fler_reg <= FC2_RESET[7];
      esu_reg  <= FC2_RESET[FC2_ESU];
      psu_reg  <= FC2_RESET[FC2_PSU];
    end else if (ce_i) begin
      if (!swe_reg) begin
        fler_reg <= 1'b0;
        esu_reg  <= 1'b0;
        psu_reg  <= 1'b0;
      end else begin
        // A fault in the same cycle as any write still sets the error bit.
        if (flash_error_i) begin
          fler_reg <= 1'b1;
        end
        if (wr_en && sel_now == SEL_FC2 && flash_en) begin
          esu_reg <= wdat[FC2_ESU];
          psu_reg <= wdat[FC2_PSU];
        end
      end
    end
  end

  // A stale block mask could erase the wrong blocks later, so it clears with the enable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ebs_reg <= EBS_RESET;
    end else if (ce_i) begin
      if (!swe_reg) begin
        ebs_reg <= 8'h00;
      end else if (wr_en && sel_now == SEL_EBS && flash_en) begin
        ebs_reg <= wdat;
      end
    end
  end

  // This register is always mapped, so software can always reach the select bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wsc_reg <= WSC_RESET;
    end else if (ce_i && wr_en && sel_now == SEL_WSC) begin
      wsc_reg <= wdat;
    end
  end

  // Mode 1 pins the bit high; modes 2 and 3 hold it low except under boot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expanded_mode_enable_reg <= (pin_sync_reg[1:0] == MODE_ONE);
    end else if (ce_i) begin
      if (mode_reg == MODE_ONE) begin
        expanded_mode_enable_reg <= 1'b1;
      end else if (boot_reg && wr_en && sel_now == SEL_MDC) begin
        expanded_mode_enable_reg <= wdat[MDC_EXPANDED_MODE_ENABLE];
      end else if (!boot_reg) begin
        expanded_mode_enable_reg <= 1'b0;
      end
    end
  end

  // The serial check and the routine transfer run outside this block.
  // Past idle, only their completion levels move the sequencer on.
  always_comb begin
    boot_state_next = boot_state_reg;
    case (boot_state_reg)
      BOOT_IDLE: begin
        if (boot_reg) begin
          boot_state_next = BOOT_CHECK;
        end
      end
      BOOT_CHECK: begin
        if (comm_ok_i) begin
          boot_state_next = BOOT_LOAD;
        end
      end
      BOOT_LOAD: begin
        if (load_done_i) begin
          boot_state_next = BOOT_READY;
        end
      end
      BOOT_READY: boot_state_next = BOOT_READY;
      default:    boot_state_next = BOOT_IDLE;
    endcase
  end

  // The sequencer leaves idle only after a reset that captured the boot pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_state_reg <= BOOT_IDLE;
    end else if (ce_i) begin
      boot_state_reg <= boot_state_next;
    end
  end

  // Mode and status outputs are registered copies, one cycle behind the registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expanded_o      <= 1'b0;
      single_chip_o   <= 1'b0;
      flash_enabled_o <= 1'b0;
      wait_state_o    <= WSC_RESET;
    end else if (ce_i) begin
      expanded_o      <= expanded_mode_enable_reg;
      single_chip_o   <= !expanded_mode_enable_reg;
      flash_enabled_o <= flash_en;
      wait_state_o    <= wsc_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_check_o   <= 1'b0;
      routine_load_o <= 1'b0;
    end else if (ce_i) begin
      boot_check_o   <= (boot_state_reg == BOOT_CHECK);
      routine_load_o <= (boot_state_reg == BOOT_LOAD);
    end
  end

  // Requests toward the flash array are registered to keep them glitch free.
  // A latched fault drops a program or erase request on the next edge; the wrong mode drops any request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_o        <= 1'b0;
      program_verify_o <= 1'b0;
      erase_verify_o   <= 1'b0;
      erase_all_o      <= 1'b0;
      erase_o          <= 1'b0;
    end else if (ce_i) begin
      program_o        <= p_reg && may_alter;
      program_verify_o <= pv_reg && flash_en;
      erase_verify_o   <= ev_reg && flash_en;
      erase_all_o      <= e_reg && may_alter && boot_reg;
      erase_o          <= e_reg && may_alter && user_prog && ebs_reg != 8'h00;
    end
  end

  // Boot mode clears every block at once; the mask only counts in user programming.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_blocks_o <= 8'h00;
      erase_kbytes_o <= 7'h00;
    end else if (ce_i) begin
      if (e_reg && may_alter && boot_reg) begin
        erase_blocks_o <= {NUM_BLOCKS{1'b1}};
        erase_kbytes_o <= TOTAL_KB;
      end else if (e_reg && may_alter && user_prog) begin
        erase_blocks_o <= ebs_reg;
        erase_kbytes_o <= block_kbytes(ebs_reg);
      end else begin
        erase_blocks_o <= 8'h00;
        erase_kbytes_o <= 7'h00;
      end
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
endmodule // flash_mode_register_bank

/* File: logic/flash_mode_pkg.sv */
// Constants and types shared by the flash and mode register bank.
package flash_mode_pkg;
  localparam int          ADR_W         = 18;
  localparam int          DAT_W         = 32;
  localparam logic [15:0] IDX_FC1       = 16'hFF80;
  localparam logic [15:0] IDX_FC2       = 16'hFF81;
  localparam logic [15:0] IDX_EBS       = 16'hFF83;
  localparam logic [15:0] IDX_WSC       = 16'hFFC2;
  localparam logic [15:0] IDX_MDC       = 16'hFFC5;
  localparam logic [7:0]  FC1_RESET     = 8'h80;
  localparam logic [7:0]  FC2_RESET     = 8'h00;
  localparam logic [7:0]  EBS_RESET     = 8'h00;
  localparam logic [7:0]  WSC_RESET     = 8'h08;
  localparam logic [7:0]  DISABLED_READ = 8'h00;
  localparam int          FC1_SWE       = 6;
  localparam int          FC1_EV        = 3;
  localparam int          FC1_PV        = 2;
  localparam int          FC1_E         = 1;
  localparam int          FC1_P         = 0;
  localparam int          FC2_ESU       = 1;
  localparam int          FC2_PSU       = 0;
  localparam int          WSC_FLSEL     = 7;
  localparam int          MDC_EXPANDED_MODE_ENABLE      = 7;
  localparam logic [7:0]  MDC_FIXED     = 8'h64;
  localparam logic [1:0]  MODE_ONE      = 2'h1;
  localparam int          NUM_BLOCKS    = 8;
  localparam logic [6:0]  TOTAL_KB      = 7'h3C;
  localparam logic [6:0]  BLOCK_KB [NUM_BLOCKS] = '{
    7'h01, 7'h01, 7'h01, 7'h01, 7'h1C, 7'h10, 7'h0C, 7'h02
  };
  typedef enum logic [2:0] {
    SEL_NONE, SEL_FC1, SEL_FC2, SEL_EBS, SEL_WSC, SEL_MDC
  } reg_sel_t;
  typedef enum logic [1:0] {
    BOOT_IDLE, BOOT_CHECK, BOOT_LOAD, BOOT_READY
  } boot_state_t;
endpackage

/* File: tb/flash_mode_register_bank_assertions.sv */
// Concurrent checks on the ports of the flash and mode register bank.
`timescale 1ns/1ns
module flash_mode_register_bank_assertions (
  input wire logic                             clk_i,           // System clock.
  input wire logic                             rst_i,           // Synchronous reset.
  input wire logic                             ce_i,            // Clock enable.
  input wire logic                             cyc_i,           // Wishbone cycle.
  input wire logic                             stb_i,           // Wishbone strobe.
  input wire logic                             we_i,            // Wishbone write.
  input wire logic [flash_mode_pkg::ADR_W-1:0] adr_i,           // Byte address.
  input wire logic [flash_mode_pkg::DAT_W-1:0] dat_o,           // Read data.
  input wire logic                             ack_o,           // Wishbone ack.
  input wire logic                             expanded_o,      // Expanded operation.
  input wire logic                             single_chip_o,   // Single-chip operation.
  input wire logic                             flash_enabled_o, // On-chip flash on.
  input wire logic [7:0]                       wait_state_o,    // Wait-state control.
  input wire logic                             program_o,       // Program request.
  input wire logic                             erase_all_o,     // Total erase request.
  input wire logic                             erase_o,         // Block erase request.
  input wire logic [7:0]                       erase_blocks_o,  // Blocks to erase.
  input wire logic [6:0]                       erase_kbytes_o   // Kbytes to erase.
);
  import flash_mode_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack longer than one cycle");
  wait_reset_a: assert property ($fell(rst_i) |-> wait_state_o == 8'h08)
    else $error("wait-state output wrong after reset");
  mode_fixed_bits_a: assert property (ack_o && !we_i && adr_i == 18'h3FF14 |->
    (dat_o[7:0] & 8'h7C) == 8'h64) else $error("mode register fixed bits wrong");
  unmapped_zero_a: assert property (ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0)
    else $error("misaligned read not zero");
  disabled_read_a: assert property (ack_o && !we_i && !flash_enabled_o &&
    adr_i inside {18'h3FE00, 18'h3FE04, 18'h3FE0C} |-> dat_o == 32'h0)
    else $error("disabled flash register read not zero");
  mode_exclusive_a: assert property (expanded_o |-> !single_chip_o)
    else $error("expanded and single-chip both high");
  erase_kinds_a: assert property (!(erase_all_o && erase_o))
    else $error("total and block erase together");
  total_erase_a: assert property (erase_all_o |-> erase_kbytes_o == 7'h3C &&
    erase_blocks_o == 8'hFF) else $error("total erase size wrong");
  block_erase_a: assert property (erase_o |-> erase_blocks_o != 8'h00)
    else $error("block erase with no block");
  program_enabled_a: assert property (program_o |-> flash_enabled_o)
    else $error("program request with flash disabled");
endmodule // flash_mode_register_bank_assertions

bind flash_mode_register_bank flash_mode_register_bank_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .expanded_o(expanded_o),
  .single_chip_o(single_chip_o), .flash_enabled_o(flash_enabled_o),
  .wait_state_o(wait_state_o), .program_o(program_o), .erase_all_o(erase_all_o),
  .erase_o(erase_o), .erase_blocks_o(erase_blocks_o), .erase_kbytes_o(erase_kbytes_o));

/* File: tb/flash_mode_register_bank_tb_top.sv */
// Self-checking bench for the flash and mode register bank.
`timescale 1ns/1ns
module flash_mode_register_bank_tb_top;
  import flash_mode_pkg::*;
  typedef struct packed {logic w; logic [17:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, md1, md0, boot, pv, fl_err, c_ok, l_done;
  logic [ADR_W-1:0] adr_i;
  logic [3:0]       sel_i;
  logic [DAT_W-1:0] dat_i, dat_o;
  logic ack_o, expanded_o, single_chip_o, flash_enabled_o, boot_check_o, routine_load_o;
  logic program_o, program_verify_o, erase_verify_o, erase_all_o, erase_o;
  logic [7:0] wait_state_o, erase_blocks_o, q;
  logic [6:0] erase_kbytes_o;
  int n_mismatch = 0;
  int n_tests = 0;
  // Reads carry the expected byte, writes leave it unused.
  localparam row_t ROWS [17] = '{
    '{1'h0, 18'h3FF08, 8'h00, 8'h08}, '{1'h0, 18'h3FE00, 8'h00, 8'h00},
    '{1'h1, 18'h3FF08, 8'h88, 8'h00}, '{1'h0, 18'h3FE00, 8'h00, 8'h80},
    '{1'h0, 18'h3FE04, 8'h00, 8'h00}, '{1'h0, 18'h3FE0C, 8'h00, 8'h00},
    '{1'h1, 18'h3FE0C, 8'h0F, 8'h00}, '{1'h0, 18'h3FE0C, 8'h00, 8'h00},
    '{1'h1, 18'h3FF14, 8'h80, 8'h00}, '{1'h0, 18'h3FF14, 8'h00, 8'h67},
    '{1'h0, 18'h3FF09, 8'h00, 8'h00}, '{1'h1, 18'h3FE00, 8'h40, 8'h00},
    '{1'h1, 18'h3FE04, 8'h02, 8'h00}, '{1'h1, 18'h3FE0C, 8'h90, 8'h00},
    '{1'h0, 18'h3FE0C, 8'h00, 8'h90}, '{1'h1, 18'h3FE00, 8'h42, 8'h00},
    '{1'h0, 18'h3FE00, 8'h00, 8'hC2}};
  flash_mode_register_bank DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .mode_pin_one_i(md1), .mode_pin_zero_i(md0), .boot_pin_i(boot), .prog_voltage_i(pv),
    .flash_error_i(fl_err), .comm_ok_i(c_ok), .load_done_i(l_done), .expanded_o(expanded_o),
    .single_chip_o(single_chip_o), .flash_enabled_o(flash_enabled_o),
    .wait_state_o(wait_state_o), .boot_check_o(boot_check_o), .routine_load_o(routine_load_o),
    .program_o(program_o), .program_verify_o(program_verify_o), .erase_verify_o(erase_verify_o),
    .erase_all_o(erase_all_o), .erase_o(erase_o), .erase_blocks_o(erase_blocks_o),
    .erase_kbytes_o(erase_kbytes_o));
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; the request is held until ack is seen at a rising edge.
  task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d,
                    output logic [7:0] rq);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {1'h1, 1'h1, w, a, 24'h0, d, 4'h1};
    @(posedge clk_i);
    while (ack_o !== 1'h1) begin
      n++;
      if (n > 20) begin
        chk("ack_o", 32'h1, {31'h0, ack_o});
        end_sim();
      end
      @(posedge clk_i);
    end
    rq = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task automatic rdc(input logic [17:0] a, input logic [7:0] e, input string nm);
    logic [7:0] r;
    wb(1'h0, a, 8'h00, r);
    chk(nm, {24'h0, e}, {24'h0, r});
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    wb(1'h1, a, d, q);
  endtask
  // Pins are applied while reset is held, so the mode is captured at release.
  task automatic do_reset(input logic p1, input logic p0, input logic b, input logic v);
    @(posedge clk_i);
    {rst_i, md1, md0, boot, pv, c_ok, l_done, fl_err} <= {1'h1, p1, p0, b, v, 3'h0};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask
  task automatic erase_seq;
    wr(18'h3FF08, 8'h88);
    wr(18'h3FE00, 8'h40);
    wr(18'h3FE04, 8'h02);
    wr(18'h3FE0C, 8'h01);
    wr(18'h3FE00, 8'h42);
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    {rst_i, ce_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {2'h3, 3'h0, 18'h0, 4'h0, 32'h0};
    {md1, md0, boot, pv, fl_err, c_ok, l_done} = 7'h0;
    do_reset(1'h1, 1'h1, 1'h0, 1'h1);
    for (int i = 0; i < 17; i++) begin
      wb(ROWS[i].w, ROWS[i].a, ROWS[i].d, q);
      if (!ROWS[i].w) chk($sformatf("row %0d", i), {24'h0, ROWS[i].e}, {24'h0, q});
    end
    repeat (3) @(posedge clk_i);
    chk("erase_o", 32'h1, {31'h0, erase_o});
    chk("erase_kbytes_o", 32'h1E, {25'h0, erase_kbytes_o});
    chk("wait_state_o", 32'h88, {24'h0, wait_state_o});
    // Programming follows the erase, so program_o must rise as the erase request drops.
    wr(18'h3FE04, 8'h01);
    wr(18'h3FE00, 8'h41);
    repeat (3) @(posedge clk_i);
    chk("program_o", 32'h1, {31'h0, program_o});
    chk("erase_o off", 32'h0, {31'h0, erase_o});
    $display("table test done");
    do_reset(1'h0, 1'h1, 1'h0, 1'h1);
    {md1, md0} <= 2'h3;
    repeat (3) @(posedge clk_i);
    rdc(18'h3FF14, 8'hE7, "mode reg mode 1");
    erase_seq();
    rdc(18'h3FE00, 8'h00, "fc1 disabled");
    chk("flash_enabled_o", 32'h0, {31'h0, flash_enabled_o});
    chk("expanded_o", 32'h1, {31'h0, expanded_o});
    $display("mode 1 test done");
    do_reset(1'h1, 1'h0, 1'h0, 1'h0);
    rdc(18'h3FF14, 8'h66, "mode reg mode 2");
    erase_seq();
    chk("user erase_o", 32'h0, {31'h0, erase_o});
    chk("single_chip_o", 32'h1, {31'h0, single_chip_o});
    $display("user mode test done");
    do_reset(1'h1, 1'h1, 1'h1, 1'h1);
    repeat (3) @(posedge clk_i);
    chk("boot_check_o", 32'h1, {31'h0, boot_check_o});
    c_ok <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("routine_load_o", 32'h1, {31'h0, routine_load_o});
    l_done <= 1'h1;
    repeat (3) @(posedge clk_i);
    wr(18'h3FF14, 8'h80);
    rdc(18'h3FF14, 8'hE7, "mode reg boot");
    erase_seq();
    chk("erase_all_o", 32'h1, {31'h0, erase_all_o});
    chk("boot erase_o", 32'h0, {31'h0, erase_o});
    chk("erase_blocks_o", 32'hFF, {24'h0, erase_blocks_o});
    fl_err <= 1'h1;
    @(posedge clk_i);
    fl_err <= 1'h0;
    rdc(18'h3FE04, 8'h82, "fc2 error");
    repeat (3) @(posedge clk_i);
    chk("erase_all_o error", 32'h0, {31'h0, erase_all_o});
    wr(18'h3FE00, 8'h4C);
    repeat (2) @(posedge clk_i);
    chk("erase_verify_o", 32'h1, {31'h0, erase_verify_o});
    chk("program_verify_o", 32'h1, {31'h0, program_verify_o});
    $display("boot mode test done");
    end_sim();
  end
endmodule // flash_mode_register_bank_tb_top
